//--- nmtp_pkg.sv
// Package for the network map table parser: field widths, table kinds,
// parser states and section kinds.
// Assumes a byte-wide table content stream from an upstream extractor.
package nmtp_pkg;
   localparam int BYTE_W = 8;
   localparam int LEN_W = 12;
   localparam int ID_W = 16;
   localparam int HDR_BYTES = 4;
   localparam logic [LEN_W-1:0] LEN_ZERO = 12'h000;
   localparam logic [LEN_W-1:0] LEN_ONE = 12'h001;
   localparam logic [LEN_W-1:0] LEN_TWO = 12'h002;
   localparam logic [LEN_W-1:0] REC_HDR_LEN = 12'h006;
   localparam logic [3:0] LEN_HI_MASK = 4'h0;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   // Which table the upstream is delivering
   localparam logic TBL_INFO = 1'b0;
   localparam logic TBL_MAP = 1'b1;
   // Tag on each output descriptor byte
   localparam logic SEC_NET = 1'b0;
   localparam logic SEC_TRANSPORT = 1'b1;

   typedef enum logic [3:0] {
      NMTP_IDLE, NMTP_NLEN_HI, NMTP_NLEN_LO, NMTP_NET, NMTP_SLEN_HI,
      NMTP_SLEN_LO, NMTP_FWD_HI, NMTP_FWD_LO, NMTP_ID2_HI, NMTP_ID2_LO,
      NMTP_TLEN_HI, NMTP_TLEN_LO, NMTP_TDESC, NMTP_DONE, NMTP_DROP
   } nmtp_state_e;
endpackage

//--- nmtp_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; the drain side may stall at any time.
`timescale 1ns/1ps
module nmtp_skid_buf
   import nmtp_pkg::*;
#(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] mem_q [2];
   logic wrPtr_q;
   logic rdPtr_q;
   logic [1:0] count_q;
   logic doWr;
   logic doRd;

   // Honest full and empty from the count
   assign inReady = (count_q != BUF_DEPTH);
   assign outValid = (count_q != 2'h0);
   assign outData = mem_q[rdPtr_q];
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;

   // Storage, written only on accepted words
   always_ff @(posedge clk_sys) begin
      if (doWr) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr_q <= 1'b0;
         rdPtr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (doWr) begin
            wrPtr_q <= ~wrPtr_q;
         end
         if (doRd) begin
            rdPtr_q <= ~rdPtr_q;
         end
         if (doWr && !doRd) begin
            count_q <= count_q + 2'h1;
         end else if (doRd && !doWr) begin
            count_q <= count_q - 2'h1;
         end
      end
   end
endmodule

//--- nmtp_len_cnt.sv
// Down counter for one counted section, stopping at zero.
// Assumes load and step are never asserted in the same cycle.
`timescale 1ns/1ps
module nmtp_len_cnt
   import nmtp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Control
   input wire logic load,
   input wire logic [LEN_W-1:0] loadVal,
   input wire logic step,
   // Status
   output logic [LEN_W-1:0] remain,
   output logic isZero
);
   logic [LEN_W-1:0] cnt_q;

   assign remain = cnt_q;
   assign isZero = (cnt_q == LEN_ZERO);

   // Count down one per consumed byte, never below zero
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= LEN_ZERO;
      end else if (load) begin
         cnt_q <= loadVal;
      end else if (step && !isZero) begin
         cnt_q <= cnt_q - LEN_ONE;
      end
   end
endmodule

//--- network_map_table_parser.sv
// Parser for the network information and service map table contents.
// Assumes upstream delivers one table per inStart..inLast burst with a
// valid/ready handshake, and that downstream may stall descriptor bytes.
`timescale 1ns/1ps
module network_map_table_parser
   import nmtp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Table content bytes from the section extractor
   input wire logic inValid,
   output logic inReady,
   input wire logic [BYTE_W-1:0] inData,
   input wire logic inStart,
   input wire logic inLast,
   input wire logic inTableKind,
   // Descriptor byte stream
   output logic descValid,
   input wire logic descReady,
   output logic [BYTE_W-1:0] descData,
   output logic descSection,
   // Record identifiers
   output logic recValid,
   output logic recTableKind,
   output logic [ID_W-1:0] recFwdMux,
   output logic [ID_W-1:0] recOriginNetIdent,
   output logic [ID_W-1:0] recReturnMux,
   // Table status
   output logic tableDone,
   output logic formatError,
   output logic busy
);
   nmtp_state_e state_q;
   nmtp_state_e state_d;
   logic kind_q;
   logic [LEN_W-BYTE_W-1:0] lenHi_q;
   logic [ID_W-1:0] fwd_q;
   logic [ID_W-1:0] id2_q;
   logic [ID_W-1:0] recFwd_q;
   logic [ID_W-1:0] recOrig_q;
   logic [ID_W-1:0] recRet_q;
   logic recValid_q;
   logic recKind_q;
   logic done_q;
   logic err_q;
   logic take;
   logic isDesc;
   logic bufReady;
   logic [LEN_W-1:0] fieldLen;
   logic errHit;
   // Section counters: stream spec and current section
   logic specLoad;
   logic secLoad;
   logic [LEN_W-1:0] specRemain;
   logic [LEN_W-1:0] secRemain;
   logic specZero;
   logic secZero;
   logic inSpec;

   // Bytes of a descriptor section need a free buffer slot
   assign isDesc = (state_q == NMTP_NET) || (state_q == NMTP_TDESC);
   assign inReady = isDesc ? bufReady : (state_q != NMTP_DONE);
   assign take = inValid && inReady;
   // Reserved nibble ahead, count MSB first
   assign fieldLen = {lenHi_q, inData};
   assign inSpec = (state_q >= NMTP_FWD_HI) && (state_q <= NMTP_TDESC);
   assign busy = (state_q != NMTP_IDLE);

   // Returns true when a count does not fit the bytes left around it
   function automatic logic overruns(input logic [LEN_W-1:0] need,
                                     input logic [LEN_W-1:0] avail);
      overruns = (need > avail);
   endfunction

   nmtp_len_cnt u_spec_cnt (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .load(specLoad),
      .loadVal(fieldLen),
      .step(take && inSpec),
      .remain(specRemain),
      .isZero(specZero)
   );
   assign specLoad = take && (state_q == NMTP_SLEN_LO);

   nmtp_len_cnt u_sec_cnt (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .load(secLoad),
      .loadVal(fieldLen),
      .step(take && isDesc),
      .remain(secRemain),
      .isZero(secZero)
   );
   assign secLoad = take && ((state_q == NMTP_NLEN_LO) ||
                             (state_q == NMTP_TLEN_LO));

   always_comb begin
      errHit = 1'b0;
      if (take) begin
         if ((state_q == NMTP_TLEN_LO) &&
             overruns(fieldLen, specRemain - LEN_ONE)) begin
            errHit = 1'b1;
         end else if ((state_q == NMTP_FWD_HI) &&
                      overruns(REC_HDR_LEN, specRemain)) begin
            errHit = 1'b1;
         end else if (inLast && (state_q != NMTP_DROP) &&
                      !((state_q == NMTP_SLEN_LO) &&
                        (fieldLen == LEN_ZERO)) &&
                      !((state_q == NMTP_TDESC) && (secRemain == LEN_ONE)
                        && (specRemain == LEN_ONE)) &&
                      !((state_q == NMTP_TLEN_LO) && (fieldLen == LEN_ZERO)
                        && (specRemain == LEN_ONE))) begin
            // Content ended before the counted sections did
            errHit = 1'b1;
         end else if (!inLast && (state_q == NMTP_SLEN_LO) &&
                      (fieldLen == LEN_ZERO)) begin
            errHit = 1'b1;
         end
      end
   end

   // Next-state walk through the table layout
   always_comb begin
      state_d = state_q;
      case (state_q)
         NMTP_IDLE: begin
            // First byte holds reserved bits and count top
            if (take && inStart) begin
               state_d = NMTP_NLEN_LO;
            end
         end
         NMTP_NLEN_LO: begin
            if (take) begin
               state_d = (fieldLen == LEN_ZERO) ? NMTP_SLEN_HI : NMTP_NET;
            end
         end
         NMTP_NET: begin
            if (take && (secRemain == LEN_ONE)) begin
               state_d = NMTP_SLEN_HI;
            end
         end
         NMTP_SLEN_HI: begin
            if (take) begin
               state_d = NMTP_SLEN_LO;
            end
         end
         NMTP_SLEN_LO: begin
            if (take) begin
               state_d = (fieldLen == LEN_ZERO) ? NMTP_DONE : NMTP_FWD_HI;
            end
         end
         NMTP_FWD_HI: begin
            if (take) begin
               state_d = NMTP_FWD_LO;
            end
         end
         NMTP_FWD_LO: begin
            if (take) begin
               state_d = NMTP_ID2_HI;
            end
         end
         NMTP_ID2_HI: begin
            if (take) begin
               state_d = NMTP_ID2_LO;
            end
         end
         NMTP_ID2_LO: begin
            if (take) begin
               state_d = NMTP_TLEN_HI;
            end
         end
         NMTP_TLEN_HI: begin
            if (take) begin
               state_d = NMTP_TLEN_LO;
            end
         end
         NMTP_TLEN_LO: begin
            if (take) begin
               if (fieldLen != LEN_ZERO) begin
                  state_d = NMTP_TDESC;
               end else if (specRemain == LEN_ONE) begin
                  state_d = NMTP_DONE;
               end else begin
                  state_d = NMTP_FWD_HI;
               end
            end
         end
         NMTP_TDESC: begin
            // Record ends, next record or table end
            if (take && (secRemain == LEN_ONE)) begin
               state_d = (specRemain == LEN_ONE) ? NMTP_DONE : NMTP_FWD_HI;
            end
         end
         NMTP_DONE: begin
            state_d = NMTP_IDLE;
         end
         NMTP_DROP: begin
            // Discard the rest of an abandoned table
            if (take && inLast) begin
               state_d = NMTP_IDLE;
            end
         end
         default: begin
            state_d = NMTP_IDLE;
         end
      endcase
      // Abandon the table on a format error
      if (errHit) begin
         state_d = inLast ? NMTP_IDLE : NMTP_DROP;
      end else if (take && inLast && (state_d != NMTP_DONE)
                   && (state_q != NMTP_DROP)) begin
         state_d = NMTP_IDLE;
      end
   end

   // State register
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= NMTP_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Field capture, MSB byte first
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         kind_q <= TBL_INFO;
         lenHi_q <= LEN_HI_MASK;
         fwd_q <= '0;
         id2_q <= '0;
      end else if (take) begin
         if (state_q == NMTP_IDLE) begin
            kind_q <= inTableKind;
         end
         if ((state_q == NMTP_IDLE) || (state_q == NMTP_SLEN_HI) ||
             (state_q == NMTP_TLEN_HI)) begin
            lenHi_q <= inData[LEN_W-BYTE_W-1:0];
         end
         if (state_q == NMTP_FWD_HI) begin
            fwd_q[ID_W-1:BYTE_W] <= inData;
         end
         if (state_q == NMTP_FWD_LO) begin
            fwd_q[BYTE_W-1:0] <= inData;
         end
         if (state_q == NMTP_ID2_HI) begin
            id2_q[ID_W-1:BYTE_W] <= inData;
         end
         if (state_q == NMTP_ID2_LO) begin
            id2_q[BYTE_W-1:0] <= inData;
         end
      end
   end

   // Record output, one-cycle strobe after the transport count
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         recValid_q <= 1'b0;
         recKind_q <= TBL_INFO;
         recFwd_q <= '0;
         recOrig_q <= '0;
         recRet_q <= '0;
      end else begin
         recValid_q <= take && (state_q == NMTP_TLEN_LO) && !errHit;
         if (take && (state_q == NMTP_TLEN_LO) && !errHit) begin
            recKind_q <= kind_q;
            // Forward label shared by both table kinds
            recFwd_q <= fwd_q;
            if (kind_q == TBL_MAP) begin
               recRet_q <= id2_q;
            end else begin
               recOrig_q <= id2_q;
            end
         end
      end
   end

   assign recValid = recValid_q;
   assign recTableKind = recKind_q;
   assign recFwdMux = recFwd_q;
   assign recOriginNetIdent = recOrig_q;
   assign recReturnMux = recRet_q;

   // Table status strobes
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         done_q <= (state_q == NMTP_DONE);
         err_q <= errHit;
      end
   end

   assign tableDone = done_q;
   assign formatError = err_q;

   // Stall by the receiver must not lose a descriptor byte
   nmtp_skid_buf #(
      .WIDTH(BYTE_W + 1)
   ) u_desc_buf (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .inValid(inValid && isDesc),
      .inReady(bufReady),
      .inData({(state_q == NMTP_TDESC) ? SEC_TRANSPORT : SEC_NET, inData}),
      .outValid(descValid),
      .outReady(descReady),
      .outData({descSection, descData})
   );
endmodule

//--- nmtp_checker.sv
// Checker for the table parser: handshake and output timing properties.
// Assumes it is bound to the parser top and sees only its ports.
`timescale 1ns/1ps
module nmtp_checker
   import nmtp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Watched ports
   input wire logic inValid,
   input wire logic inReady,
   input wire logic inStart,
   input wire logic inLast,
   input wire logic descValid,
   input wire logic descReady,
   input wire logic [BYTE_W-1:0] descData,
   input wire logic descSection,
   input wire logic recValid,
   input wire logic [ID_W-1:0] recFwdMux,
   input wire logic [ID_W-1:0] recOriginNetIdent,
   input wire logic [ID_W-1:0] recReturnMux,
   input wire logic tableDone,
   input wire logic formatError,
   input wire logic busy
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // A byte handed over, and the closing byte of a running table
   sequence s_take; inValid && inReady; endsequence
   sequence s_end; s_take ##0 (inLast && busy); endsequence
   property p_start; (!busy && inStart) ##0 s_take |=> busy; endproperty
   property p_stray; (!busy && !inStart) ##0 s_take |=> !busy; endproperty
   property p_end; s_end |-> ##[1:3] !busy; endproperty
   property p_desc;
      descValid && !descReady |=>
         descValid && $stable(descData) && $stable(descSection);
   endproperty
   property p_hold;
      !recValid |-> $stable(recFwdMux) && $stable(recOriginNetIdent)
         && $stable(recReturnMux);
   endproperty
   property p_rec; recValid |-> $past(busy) && !$past(recValid); endproperty
   property p_done; tableDone |=> !tableDone; endproperty
   property p_err; formatError |-> !tableDone ##1 !formatError; endproperty
   a_start: assert property (p_start) else $error("start ignored");
   a_stray: assert property (p_stray) else $error("stray byte ran");
   a_end: assert property (p_end) else $error("no idle after end");
   a_desc: assert property (p_desc) else $error("desc lost");
   a_hold: assert property (p_hold) else $error("ids moved");
   a_rec: assert property (p_rec) else $error("rec while idle");
   a_done: assert property (p_done) else $error("done too long");
   a_err: assert property (p_err) else $error("error with done");
endmodule

bind network_map_table_parser nmtp_checker chk_u (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .inValid(inValid), .inReady(inReady),
   .inStart(inStart), .inLast(inLast), .descValid(descValid),
   .descReady(descReady), .descData(descData), .descSection(descSection),
   .recValid(recValid), .recFwdMux(recFwdMux),
   .recOriginNetIdent(recOriginNetIdent), .recReturnMux(recReturnMux),
   .tableDone(tableDone), .formatError(formatError), .busy(busy));

//--- nmtp_upstream_model.sv
// Upstream extractor model: hands queued table bytes to the parser.
// Assumes the bench fills q and sets gap for slow delivery.
`timescale 1ns/1ps
module nmtp_upstream_model
   import nmtp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Byte stream toward the parser
   output logic inValid,
   input wire logic inReady,
   output logic [BYTE_W-1:0] inData,
   output logic inStart,
   output logic inLast,
   output logic inTableKind
);
   // ------------------------------------------------------------
   // Byte delivery
   // ------------------------------------------------------------
   logic [10:0] q[$];
   int gap = 0;
   int waitCnt = 0;
   logic [10:0] e;
   // Known levels before the first edge
   initial begin
      {inValid, inTableKind, inStart, inLast, inData} = 12'h000;
   end
   // Hold each byte until taken; idle start, last and data lines scramble so nothing stale
   // looks like a valid byte
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         inValid <= 1'b0;
      end else if (!inValid || inReady) begin
         if (q.size() > 0 && waitCnt == 0) begin
            e = q.pop_front();
            {inTableKind, inStart, inLast, inData} <= e;
            inValid <= 1'b1;
            waitCnt <= gap;
         end else begin
            inValid <= 1'b0;
            {inStart, inLast, inData} <= ~{inStart, inLast, inData};
            if (waitCnt > 0) waitCnt <= waitCnt - 1;
         end
      end
   end
endmodule

//--- network_map_table_parser_tb.sv
// Testbench for the table parser with upstream model and stalling drain.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module network_map_table_parser_tb
   import nmtp_pkg::*;
;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic descReady = 1'b1;
   logic stall = 1'b0;
   logic sawFull = 1'b0;
   logic inValid, inReady, inStart, inLast, inTableKind;
   logic descValid, descSection, recValid, recTableKind;
   logic tableDone, formatError, busy;
   logic [BYTE_W-1:0] inData, descData;
   logic [ID_W-1:0] recFwdMux, recOriginNetIdent, recReturnMux;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int nDone = 0;
   int nErr = 0;
   logic [8:0] gotD[$];
   logic [32:0] gotR[$];

   always #5 clk_sys = ~clk_sys;

   network_map_table_parser dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .inValid(inValid), .inReady(inReady), .inData(inData),
      .inStart(inStart), .inLast(inLast), .inTableKind(inTableKind),
      .descValid(descValid), .descReady(descReady), .descData(descData),
      .descSection(descSection), .recValid(recValid),
      .recTableKind(recTableKind), .recFwdMux(recFwdMux),
      .recOriginNetIdent(recOriginNetIdent), .recReturnMux(recReturnMux),
      .tableDone(tableDone), .formatError(formatError), .busy(busy));
   nmtp_upstream_model up_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .inValid(inValid), .inReady(inReady), .inData(inData),
      .inStart(inStart), .inLast(inLast), .inTableKind(inTableKind));

   // Drain side stalls 7 of 8 cycles when asked; collect all outputs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      descReady <= !stall || (cyc % 8 == 0);
      if ((descValid && descReady) === 1'b1)
         gotD.push_back({descSection, descData});
      if (recValid === 1'b1)
         gotR.push_back({recTableKind, recFwdMux,
            recTableKind ? recReturnMux : recOriginNetIdent});
      if (tableDone === 1'b1) nDone <= nDone + 1;
      if (formatError === 1'b1) nErr <= nErr + 1;
      if ((inValid && !inReady && descValid && !descReady) === 1'b1)
         sawFull <= 1'b1;
      if (cyc > 50000) begin
         errors++;
         $display("BAD %0t cycle limit", $time);
         conclude();
      end
   end

   task conclude;
      if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task check(input logic [32:0] got, input logic [32:0] exp,
      input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Queue one table, start flag on first byte, last flag on final one
   task put(input logic k, input logic [7:0] b[$]);
      foreach (b[i]) up_u.q.push_back({k, i == 0, i == b.size() - 1, b[i]});
   endtask

   task chkD(input logic [8:0] e[$]);
      check(33'(gotD.size()), 33'(e.size()), "desc count");
      foreach (e[i]) begin
         if (i < gotD.size()) begin
            check(33'(gotD[i]), 33'(e[i]), "desc");
         end
      end
      gotD = {};
   endtask

   task chkR(input logic [32:0] e[$]);
      check(33'(gotR.size()), 33'(e.size()), "rec count");
      foreach (e[i]) if (i < gotR.size()) check(gotR[i], e[i], "rec");
      gotR = {};
   endtask

   // Bounded wait for pulse counts, empty feed and drained buffer
   task waitEnd(input int dn, input int en);
      int n;
      n = 0;
      while (n < 3000 && !(nDone == dn && nErr == en && up_u.q.size() == 0
         && busy === 1'b0 && descValid === 1'b0)) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 3000) begin
         errors++;
         $display("BAD %0t wait ran out", $time);
         conclude();
      end
   endtask

   // Info table after a stray byte; reserved nibbles set high
   task t_info;
      up_u.q.push_back(11'h055);
      put(1'b0, '{8'hF0, 8'h02, 8'hAA, 8'hBB, 8'hF0, 8'h0E, 8'h12, 8'h34,
         8'h56, 8'h78, 8'hF0, 8'h02, 8'hC1, 8'hC2, 8'h9A, 8'hBC, 8'hDE,
         8'hF0, 8'hF0, 8'h00});
      waitEnd(1, 0);
      chkD('{9'h0AA, 9'h0BB, 9'h1C1, 9'h1C2});
      chkR('{{1'b0, 16'h1234, 16'h5678},
         {1'b0, 16'h9ABC, 16'hDEF0}});
   endtask

   // Map table, slow feed and stalled drain fill the buffer
   task t_map;
      stall <= 1'b1;
      up_u.gap <= 2;
      @(posedge clk_sys);
      put(1'b1, '{8'hF0, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hF0,
         8'h10, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'hF0, 8'h02, 8'hE1, 8'hE2,
         8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'hF0, 8'h02, 8'hE3, 8'hE4});
      waitEnd(2, 0);
      check(33'(sawFull), 33'(1), "no refusal");
      chkD('{9'h011, 9'h022, 9'h033, 9'h044, 9'h055, 9'h1E1, 9'h1E2,
         9'h1E3, 9'h1E4});
      chkR('{{1'b1, 16'h0A0B, 16'h0C0D},
         {1'b1, 16'h0A0B, 16'h0C0E}});
      stall <= 1'b0;
      up_u.gap <= 0;
   endtask

   // Overrun, empty spec section, early end, all back to back
   task t_err;
      put(1'b0, '{8'hF0, 8'h00, 8'hF0, 8'h06, 8'h01, 8'h02, 8'h03, 8'h04,
         8'hF0, 8'h05, 8'h77, 8'h77});
      put(1'b1, '{8'hF0, 8'h00, 8'hF0, 8'h00});
      put(1'b1, '{8'hF0, 8'h03, 8'hAA});
      waitEnd(3, 2);
      check(33'(gotR.size()), 33'(0), "rec kept");
      chkD('{9'h0AA});
      gotR = {};
   endtask

   // Reset for 20 cycles, then the scenarios
   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_info();
      t_map();
      t_err();
      conclude();
   end
endmodule
